// ### magc_mux_guard.v
// serial register slave with mux addressing and input guard control
// assumes host drives sdi on rising sclk; all pins are asynchronous to clock
// assumes sclk holds each level for at least four system clocks
`timescale 1ns/1ps
`include "magc_defines.vh"

module magc_mux_guard #(
  parameter GUARD_TICK_CYCLES = `MAGC_GUARD_TICK_NS / `MAGC_CLK_PERIOD_NS,
  parameter GPIO_WIDTH        = `MAGC_GPIO_WIDTH
) (
  input  wire                  clock,
  input  wire                  rst_b,
  input  wire                  sclk,
  input  wire                  csB,
  input  wire                  sdi,
  output wire                  sdo,
  output wire                  sdoOe,
  input  wire [GPIO_WIDTH-1:0] gpioIn,
  output wire [GPIO_WIDTH-1:0] gpioOut,
  output wire [GPIO_WIDTH-1:0] gpioOe,
  output wire [4:0]            gainCode,
  output wire                  guardActive
);

  localparam PH_CMD   = 3'd0;
  localparam PH_WDATA = 3'd1;
  localparam PH_WCHK  = 3'd2;
  localparam PH_RD1   = 3'd3;
  localparam PH_RD2   = 3'd4;
  localparam PH_SKIP  = 3'd5;

  // pin synchronisers, first stage read only by the second
  reg [2:0]            sclkSync_reg;
  reg [2:0]            csSync_reg;
  reg [1:0]            sdiSync_reg;
  reg [GPIO_WIDTH-1:0] gpioMeta_reg;
  reg [GPIO_WIDTH-1:0] gpioSync_reg;

  reg [2:0]            phase_reg;
  reg [2:0]            phase_next;
  reg [2:0]            bitCnt_reg;
  reg [7:0]            shiftIn_reg;
  reg [4:0]            addr_reg;
  reg [15:0]           shiftOut_reg;
  reg                  sdoOe_reg;

  reg [7:0]            gain_reg;
  reg [7:0]            guardTmo_reg;
  reg [7:0]            direction_reg;
  reg [7:0]            special_reg;
  reg [2:0]            chanPins_reg;
  reg [GPIO_WIDTH-1:0] gpioOut_reg;
  reg [GPIO_WIDTH-1:0] gpioOe_reg;
  reg                  armPulse_reg;
  reg                  startPulse_reg;
  reg [7:0]            readData;

  wire                 sclkFall;
  wire                 sclkRise;
  wire                 csRise;
  wire                 csLow;
  wire [7:0]           byteIn;
  wire                 byteDone;
  wire [2:0]           cmdOp;
  wire                 guardNow;
  wire                 extTrigger;
  wire                 cmdDone;
  wire                 readLoad;
  wire                 readEnd;
  wire                 readStep;

  assign sclkFall = csLow && sclkSync_reg[2] && !sclkSync_reg[1];
  assign sclkRise = csLow && !sclkSync_reg[2] && sclkSync_reg[1];
  assign csRise   = !csSync_reg[2] && csSync_reg[1];
  assign csLow    = !csSync_reg[1];
  assign byteIn   = {shiftIn_reg[6:0], sdiSync_reg[1]};
  assign byteDone = sclkFall && (bitCnt_reg == `MAGC_BIT_LAST);
  assign cmdOp    = byteIn[`MAGC_CMD_OP_MSB:`MAGC_CMD_OP_LSB];
  assign cmdDone  = byteDone && (phase_reg == PH_CMD);
  assign readLoad = cmdDone && (cmdOp == `MAGC_OP_READ);
  assign readEnd  = byteDone && (phase_reg == PH_RD2);
  // first rising edge of the read window already shows bit 15
  assign readStep = sclkRise && (phase_reg == PH_RD2 ||
                    (phase_reg == PH_RD1 && bitCnt_reg != `MAGC_BIT_ZERO));

  always @(posedge clock) begin
    if (!rst_b) begin
      sclkSync_reg <= 3'h0;
      csSync_reg   <= 3'h7;
      sdiSync_reg  <= 2'h0;
      gpioMeta_reg <= {GPIO_WIDTH{1'b0}};
      gpioSync_reg <= {GPIO_WIDTH{1'b0}};
    end else begin
      sclkSync_reg <= {sclkSync_reg[1:0], sclk};
      csSync_reg   <= {csSync_reg[1:0], csB};
      sdiSync_reg  <= {sdiSync_reg[0], sdi};
      gpioMeta_reg <= gpioIn;
      gpioSync_reg <= gpioMeta_reg;
    end
  end

  // read mux over the implemented registers, others read zero
  always @* begin
    case (byteIn[`MAGC_CMD_ADDR_MSB:`MAGC_CMD_ADDR_LSB])
      `MAGC_REG_GAIN:      readData = gain_reg;
      `MAGC_REG_GUARD_TMO: readData = guardTmo_reg;
      `MAGC_REG_DIRECTION: readData = direction_reg;
      `MAGC_REG_SPECIAL:   readData = special_reg;
      default:             readData = `MAGC_ZERO_BYTE;
    endcase
  end

  // byte phase sequencing within one frame
  always @* begin
    phase_next = phase_reg;
    case (phase_reg)
      PH_CMD: begin
        if (cmdOp == `MAGC_OP_WRITE || cmdOp == `MAGC_OP_WRITE_GUARD)
          phase_next = PH_WDATA;
        else if (cmdOp == `MAGC_OP_READ)
          phase_next = PH_RD1;
        else
          phase_next = PH_SKIP; // unsupported commands idle out the frame
      end
      PH_WDATA: phase_next = PH_WCHK;
      PH_WCHK:  phase_next = PH_CMD; // check byte always ignored
      PH_RD1:   phase_next = PH_RD2;
      PH_RD2:   phase_next = PH_CMD;
      PH_SKIP:  phase_next = PH_SKIP;
      default:  phase_next = PH_CMD;
    endcase
  end

  always @(posedge clock) begin
    if (!rst_b) begin
      phase_reg    <= PH_CMD;
      bitCnt_reg   <= `MAGC_BIT_ZERO;
      shiftIn_reg  <= `MAGC_ZERO_BYTE;
      addr_reg     <= 5'h00;
      armPulse_reg <= 1'b0;
    end else if (!csLow) begin
      // a partial byte at frame close is dropped here
      phase_reg    <= PH_CMD;
      bitCnt_reg   <= `MAGC_BIT_ZERO;
      armPulse_reg <= 1'b0;
    end else begin
      armPulse_reg <= 1'b0;
      if (sclkFall) begin
        shiftIn_reg <= byteIn;
        bitCnt_reg  <= bitCnt_reg + 3'h1;
      end
      if (byteDone)
        phase_reg <= phase_next;
      if (cmdDone) begin
        addr_reg <= byteIn[`MAGC_CMD_ADDR_MSB:`MAGC_CMD_ADDR_LSB];
        if (cmdOp == `MAGC_OP_WRITE_GUARD)
          armPulse_reg <= 1'b1;
      end
    end
  end

  // read shifter, loaded by the read command and emptied over sixteen clocks
  always @(posedge clock) begin
    if (!rst_b) begin
      shiftOut_reg <= 16'h0000;
      sdoOe_reg    <= 1'b0;
    end else if (!csLow) begin
      sdoOe_reg    <= 1'b0;
    end else if (readLoad) begin
      shiftOut_reg <= {readData, `MAGC_CHECK_DEFAULT};
      sdoOe_reg    <= 1'b1;
    end else begin
      if (readEnd)
        sdoOe_reg <= 1'b0;
      if (readStep)
        shiftOut_reg <= {shiftOut_reg[14:0], 1'b0};
    end
  end

  // register writes land on the data byte
  always @(posedge clock) begin
    if (!rst_b) begin
      gain_reg      <= `MAGC_GAIN_RESET;
      guardTmo_reg  <= `MAGC_GUARD_TMO_RESET;
      direction_reg <= `MAGC_ZERO_BYTE;
      special_reg   <= `MAGC_ZERO_BYTE;
    end else if (byteDone && phase_reg == PH_WDATA) begin
      case (addr_reg)
        `MAGC_REG_GAIN:      gain_reg      <= byteIn;
        `MAGC_REG_GUARD_TMO: guardTmo_reg  <= byteIn;
        `MAGC_REG_DIRECTION: direction_reg <= byteIn;
        `MAGC_REG_SPECIAL:   special_reg   <= byteIn;
        default: begin
        end
      endcase
    end
  end

  // channel pins move only on frame close so the guard leads the transient
  always @(posedge clock) begin
    if (!rst_b) begin
      chanPins_reg   <= 3'h0;
      startPulse_reg <= 1'b0;
    end else begin
      startPulse_reg <= csRise;
      if (csRise)
        chanPins_reg <= gain_reg[`MAGC_CHAN_MSB:`MAGC_CHAN_LSB];
      else
        chanPins_reg <= chanPins_reg;
    end
  end

  // trigger only counts when its pin is assigned and left an input
  assign extTrigger = special_reg[`MAGC_SF_TRIG] && !direction_reg[`MAGC_PIN_TRIG] &&
                      gpioSync_reg[`MAGC_PIN_TRIG];

  magc_guard_timer #(
    .TICK_CYCLES (GUARD_TICK_CYCLES)
  ) guardTimer (
    .clock       (clock),
    .rst_b       (rst_b),
    .armPulse    (armPulse_reg),
    .startPulse  (startPulse_reg),
    .extTrigger  (extTrigger),
    .timeout     (guardTmo_reg),
    .guardActive (guardNow)
  );

  // per-pin function select, registered; the function is fixed per pin at elaboration
  // so the three-bit channel latch is never indexed past its width
  genvar pin;
  generate
    for (pin = 0; pin < GPIO_WIDTH; pin = pin + 1) begin : pinMux
      always @(posedge clock) begin
        if (!rst_b)
          gpioOe_reg[pin] <= 1'b0;
        else
          gpioOe_reg[pin] <= direction_reg[pin];
      end
      if (pin >= `MAGC_SF_CHAN0 && pin <= `MAGC_SF_CHAN2) begin : chanPin
        always @(posedge clock) begin
          if (!rst_b)
            gpioOut_reg[pin] <= 1'b0;
          else if (special_reg[pin])
            gpioOut_reg[pin] <= chanPins_reg[pin];
          else
            gpioOut_reg[pin] <= 1'b0;
        end
      end else if (pin == `MAGC_PIN_GUARD) begin : guardPin
        always @(posedge clock) begin
          if (!rst_b)
            gpioOut_reg[pin] <= 1'b0;
          else if (special_reg[`MAGC_SF_GUARD])
            gpioOut_reg[pin] <= guardNow;
          else
            gpioOut_reg[pin] <= 1'b0;
        end
      end else begin : plainPin
        always @(posedge clock) begin
          gpioOut_reg[pin] <= 1'b0;
        end
      end
    end
  endgenerate

  assign gpioOut     = gpioOut_reg;
  assign gpioOe      = gpioOe_reg;
  assign sdo         = shiftOut_reg[15];
  assign sdoOe       = sdoOe_reg;
  assign gainCode    = gain_reg[`MAGC_GAINF_MSB:`MAGC_GAINF_LSB];
  assign guardActive = guardNow;

endmodule // magc_mux_guard

// ### magc_defines.vh
// constants for the mux address and guard control block
// assumes a single 50 MHz system clock and a mode-1 style serial frame
`ifndef MAGC_DEFINES_VH
`define MAGC_DEFINES_VH

// clock and guard tick timing
`define MAGC_CLK_PERIOD_NS   20
`define MAGC_GUARD_TICK_NS   1000

// register indices
`define MAGC_REG_GAIN        5'h00
`define MAGC_REG_GUARD_TMO   5'h03
`define MAGC_REG_DIRECTION   5'h08
`define MAGC_REG_SPECIAL     5'h0C

// reset values
`define MAGC_GAIN_RESET      8'h18
`define MAGC_ZERO_BYTE       8'h00
`define MAGC_GUARD_TMO_RESET 8'h01
`define MAGC_CHECK_DEFAULT   8'h00

// gain register fields
`define MAGC_GAIN_UNITY      8'h18
`define MAGC_CHAN_MSB        2
`define MAGC_CHAN_LSB        0
`define MAGC_GAINF_MSB       7
`define MAGC_GAINF_LSB       3

// command byte decode
`define MAGC_CMD_OP_MSB      7
`define MAGC_CMD_OP_LSB      5
`define MAGC_CMD_ADDR_MSB    4
`define MAGC_CMD_ADDR_LSB    0
`define MAGC_OP_WRITE        3'h2
`define MAGC_OP_WRITE_GUARD  3'h3
`define MAGC_OP_READ         3'h4

// special-function and pin positions
`define MAGC_SF_CHAN0        0
`define MAGC_SF_CHAN2        2
`define MAGC_SF_TRIG         4
`define MAGC_SF_GUARD        5
`define MAGC_PIN_TRIG        4
`define MAGC_PIN_GUARD       5
`define MAGC_GPIO_WIDTH      8

// frame and shift counts
`define MAGC_BIT_LAST        3'h7
`define MAGC_BIT_ZERO        3'h0
`define MAGC_READ_BITS       16

`endif

// ### magc_guard_timer.v
// guard timer: holds the guard active and times it out
// assumes arm, start and trigger are already in the system clock domain
`timescale 1ns/1ps
`include "magc_defines.vh"

module magc_guard_timer #(
  parameter TICK_CYCLES = `MAGC_GUARD_TICK_NS / `MAGC_CLK_PERIOD_NS
) (
  input  wire       clock,
  input  wire       rst_b,
  input  wire       armPulse,
  input  wire       startPulse,
  input  wire       extTrigger,
  input  wire [7:0] timeout,
  output wire       guardActive
);

  reg        activeReg;
  reg        pendingReg;
  reg [7:0]  countReg;
  reg [31:0] tickReg;
  wire       tickDone;

  assign tickDone    = (tickReg == TICK_CYCLES - 1);
  assign guardActive = activeReg;

  always @(posedge clock) begin
    if (!rst_b) begin
      activeReg  <= 1'b0;
      pendingReg <= 1'b0;
      countReg   <= `MAGC_ZERO_BYTE;
      tickReg    <= 32'h0000_0000;
    end else if (armPulse) begin
      // active from the command byte, but held until the frame closes
      activeReg  <= 1'b1;
      pendingReg <= 1'b1;
      tickReg    <= 32'h0000_0000;
    end else if (extTrigger) begin
      activeReg  <= 1'b1;
      pendingReg <= 1'b0;
      countReg   <= timeout;
      tickReg    <= 32'h0000_0000;
    end else if (startPulse && pendingReg) begin
      pendingReg <= 1'b0;
      countReg   <= timeout;
      tickReg    <= 32'h0000_0000;
    end else if (activeReg && !pendingReg) begin
      if (tickDone) begin
        tickReg <= 32'h0000_0000;
        if (countReg == `MAGC_ZERO_BYTE)
          activeReg <= 1'b0;
        else
          countReg <= countReg - 8'h01;
      end else begin
        tickReg <= tickReg + 32'h0000_0001;
      end
    end
  end

endmodule // magc_guard_timer

// ### magc_mux_guard_asserts.sv
// checker: timing relations at the pins of the mux and guard block
// assumes it is bound onto magc_mux_guard; one clock domain
`timescale 1ns/1ps
module magc_mux_guard_asserts #(
  parameter GUARD_TICK_CYCLES = 50,
  parameter GPIO_WIDTH        = 8
) (
  input wire                  clock,
  input wire                  rst_b,
  input wire                  sclk,
  input wire                  csB,
  input wire                  sdi,
  input wire                  sdo,
  input wire                  sdoOe,
  input wire [GPIO_WIDTH-1:0] gpioIn,
  input wire [GPIO_WIDTH-1:0] gpioOut,
  input wire [GPIO_WIDTH-1:0] gpioOe,
  input wire [4:0]            gainCode,
  input wire                  guardActive
);
  logic       sclkQ_reg;
  logic [5:0] rdFalls_reg;
  // serial clock falls seen while the read window is open
  always @(posedge clock) begin
    sclkQ_reg   <= sclk;
    rdFalls_reg <= !sdoOe ? 6'h00 : rdFalls_reg + {5'h00, sclkQ_reg && !sclk};
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence armInFrame;
    !csB ##0 $rose(guardActive);
  endsequence
  a_reset_quiet: assert property (disable iff (1'b0) !rst_b |=> gpioOut == '0 && !guardActive && !sdoOe)
    else $error("outputs not quiet after reset");
  a_guard_cause: assert property ($rose(guardActive) |-> !$past(csB, 3) || $past(gpioIn[4], 3))
    else $error("guard rose without command or trigger");
  a_guard_frame: assert property (armInFrame |-> guardActive [*8])
    else $error("guard timed out inside the frame");
  a_guard_pin: assert property (gpioOut[5] |-> $past(guardActive))
    else $error("guard pin high while guard idle");
  a_guard_drop: assert property ($fell(guardActive) |=> !gpioOut[5])
    else $error("guard pin outlived the guard");
  a_chan_hold: assert property ($changed(gpioOut[2:0]) && $past(gpioOut[2:0]) != 3'h0 && gpioOut[2:0] != 3'h0
    |-> $past(csB, 2) || $past(csB, 3) || $past(csB, 4))
    else $error("channel pins moved inside a frame");
  a_sdo_quiet: assert property (csB [*4] |-> !sdoOe)
    else $error("serial output driven outside a frame");
  a_read_sixteen: assert property ($fell(sdoOe) && !csB |-> rdFalls_reg == 6'h10)
    else $error("read window not sixteen clocks");
endmodule // magc_mux_guard_asserts

bind magc_mux_guard magc_mux_guard_asserts #(.GUARD_TICK_CYCLES(GUARD_TICK_CYCLES), .GPIO_WIDTH(GPIO_WIDTH))
  magc_mux_guard_asserts_inst (.clock(clock), .rst_b(rst_b), .sclk(sclk), .csB(csB), .sdi(sdi), .sdo(sdo),
  .sdoOe(sdoOe), .gpioIn(gpioIn), .gpioOut(gpioOut), .gpioOe(gpioOe), .gainCode(gainCode),
  .guardActive(guardActive));

// ### magc_host_model.sv
// host model: drives serial frames into the block
// assumes the shared clock; half period of six clocks covers the synchronisers
`timescale 1ns/1ps
module magc_host_model (
  input  wire  clock,
  output logic sclk,
  output logic csB,
  output logic sdi,
  input  wire  sdo,
  input  wire  sdoOe
);
  // no pull on the data-out line: an undriven line reads inverted
  wire sdoSeen;
  assign sdoSeen = sdoOe ? sdo : !sdo;
  initial begin
    sclk = 1'b0;
    csB  = 1'b1;
    sdi  = 1'b0;
  end
  // released data line flips so a stale bit never looks valid
  task automatic frame(input bit on);
    @(posedge clock);
    csB <= !on;
    sdi <= ~sdi;
  endtask
  // change on rise, both ends sample on fall
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      @(posedge clock);
      sdi  <= tx[i];
      sclk <= 1'b1;
      repeat (6) @(posedge clock);
      rx[i] = sdoSeen;
      sclk <= 1'b0;
      repeat (5) @(posedge clock);
    end
  endtask
endmodule // magc_host_model

// ### tb.sv
// testbench: register frames through the host model, pin checks
// assumes the host model and checker are compiled first
`timescale 1ns/1ps
module tb;
  localparam T = 2;
  logic       clock  = 1'b0;
  logic       rst_b  = 1'b0;
  logic [7:0] gpioIn = 8'h00;
  wire        sclk, csB, sdi, sdo, sdoOe, guardActive;
  wire  [7:0] gpioOut, gpioOe;
  wire  [4:0] gainCode;
  logic [7:0] rx;
  int         fails     = 0;
  int         tests_run = 0;
  int         cycles    = 0;
  int         n, m;
  always #10 clock = ~clock;
  magc_host_model magc_host_model_inst (.clock(clock), .sclk(sclk), .csB(csB), .sdi(sdi), .sdo(sdo),
    .sdoOe(sdoOe));
  magc_mux_guard #(.GUARD_TICK_CYCLES(T)) magc_mux_guard_inst (.clock(clock), .rst_b(rst_b), .sclk(sclk),
    .csB(csB), .sdi(sdi), .sdo(sdo), .sdoOe(sdoOe), .gpioIn(gpioIn), .gpioOut(gpioOut), .gpioOe(gpioOe),
    .gainCode(gainCode), .guardActive(guardActive));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict;
    if (fails == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      give_verdict();
    end
  end
  task automatic xb(input logic [7:0] b);
    magc_host_model_inst.xfer(b, rx);
  endtask
  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    xb(c);
    xb(d);
    xb(8'h00);
  endtask
  task automatic open;
    magc_host_model_inst.frame(1'b1);
    repeat (6) @(posedge clock);
  endtask
  // guard length counted from the call: the frame close in shut, one clock after the trigger release in the trigger test
  task automatic glen(output int len);
    len = 0;
    while (guardActive === 1'b1 && len < 200) begin
      @(posedge clock);
      len++;
    end
  endtask
  task automatic shut(output int len);
    magc_host_model_inst.frame(1'b0);
    glen(len);
    repeat (6) @(posedge clock);
  endtask
  initial begin
    repeat (20) @(posedge clock);
    rst_b <= 1'b1;
    repeat (6) @(posedge clock);
    check("gain", {3'h0, gainCode}, 8'h03);
    check("pins", gpioOut | gpioOe, 8'h00);
    open;
    wr(8'h48, 8'hFF);
    wr(8'h4C, 8'h07);
    shut(n);
    check("dir", gpioOe, 8'hFF);
    open;
    wr(8'h60, 8'h1B);
    check("chan early", {5'h00, gpioOut[2:0]}, 8'h00);
    check("armed", 8'(guardActive), 8'h01);
    wr(8'h64, 8'hFF);
    xb(8'h80);
    check("sdo oe", 8'(sdoOe), 8'h01);
    xb(8'h00);
    check("rd data", rx, 8'h1B);
    xb(8'h00);
    check("rd chk", rx, 8'h00);
    shut(n);
    check("g short", 8'(n >= 2 * T && n <= 2 * T + 10), 8'h01);
    check("chan", {5'h00, gpioOut[2:0]}, 8'h03);
    check("gain", {3'h0, gainCode}, 8'h03);
    open;
    wr(8'h43, 8'h10);
    wr(8'h60, 8'h1D);
    shut(m);
    check("g long", 8'(m - n >= 15 * T - 3 && m - n <= 15 * T + 3), 8'h01);
    check("chan", {5'h00, gpioOut[2:0]}, 8'h05);
    open;
    xb(8'h81);
    xb(8'h00);
    check("unmapped", rx, 8'h00);
    xb(8'h00);
    xb(8'h83);
    xb(8'h00);
    check("tmo rd", rx, 8'h10);
    xb(8'h00);
    shut(n);
    check("chan hold", {5'h00, gpioOut[2:0]}, 8'h05);
    open;
    xb(8'h00);
    wr(8'h40, 8'h27);
    shut(n);
    check("skip gain", {3'h0, gainCode}, 8'h03);
    check("skip chan", {5'h00, gpioOut[2:0]}, 8'h05);
    open;
    wr(8'h48, 8'h6F);
    wr(8'h4C, 8'h30);
    shut(n);
    check("dir trig", gpioOe, 8'h6F);
    check("chan off", {5'h00, gpioOut[2:0]}, 8'h00);
    gpioIn <= 8'h10;
    repeat (80) @(posedge clock);
    check("held", 8'(guardActive), 8'h01);
    check("pin", 8'(gpioOut[5]), 8'h01);
    gpioIn <= 8'h00;
    @(posedge clock);
    glen(n);
    check("trig out", 8'(n >= 17 * T && n <= 17 * T + 10), 8'h01);
    repeat (3) @(posedge clock);
    check("pin off", 8'(gpioOut[5]), 8'h00);
    give_verdict();
  end
endmodule // tb
